/* verilog/cml_pkg.sv */
// Shared constants and types for the programmable logic fabric model.
// Assumes one 100 MHz clock; configuration words are held in the top level.
package cml_pkg;
  // Fabric geometry
  localparam int MC_PER_BLOCK = 16;
  localparam int CHAIN_LEN    = 8;
  localparam int NUM_PT       = 5;
  localparam int NUM_ROUTED   = 36;
  localparam int NUM_DED      = 4;
  localparam int MAX_SETS     = 3;
  localparam int ARR_W        = NUM_ROUTED + MC_PER_BLOCK;
  // Configuration word map, in word indices
  localparam int PT_WORDS     = 4;
  localparam int MC_WORDS     = 1 + NUM_PT * PT_WORDS;
  localparam int ROUTE_BASE   = MC_PER_BLOCK * MC_WORDS;
  localparam int ROUTE_WORDS  = 3;
  localparam int BLOCK_STRIDE = 512;
  localparam int CTRL_IDX     = 0;
  localparam int GCLK_IDX     = 1;
  localparam int OE_IDX       = 2;
  localparam int PIN_IDX      = 16;
  localparam int STAT_IDX     = 96;
  // Dedicated input positions
  localparam int DED_CLK1     = 0;
  localparam int DED_CLK2     = 1;
  localparam int DED_OE1      = 2;
  localparam int DED_CLR      = 3;
  // Macrocell mode word fields
  localparam int F_FF         = 0;
  localparam int F_BYP        = 2;
  localparam int F_CLK        = 3;
  localparam int F_GSEL       = 5;
  localparam int F_INV        = 6;
  localparam int F_INIT       = 7;
  localparam int F_GCLR       = 8;
  localparam int F_FAST       = 9;
  localparam int F_SETUP      = 10;
  localparam int F_SEC        = 11;
  localparam int F_SHARE      = 16;
  localparam int F_LEND       = 17;
  localparam int F_BORROW     = 18;
  // Roles of product terms steered to the register
  localparam int PT_ACLK      = 0;
  localparam int PT_CE        = 1;
  localparam int PT_CLR       = 2;
  localparam int PT_PRE       = 3;
  localparam int PT_AUX       = 4;
  // Pin output enable selection codes and bus answers
  localparam logic [3:0]  OE_TIE_LOW  = 4'h0;
  localparam logic [3:0]  OE_TIE_HIGH = 4'h1;
  localparam logic [3:0]  OE_GLOBAL   = 4'h2;
  localparam logic [31:0] CFG_RESET   = 32'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {CML_FF_D, CML_FF_T, CML_FF_JK, CML_FF_SR} cml_ff_e;
  typedef enum logic [1:0] {CML_CLK_GLOBAL, CML_CLK_GATED, CML_CLK_ARRAY} cml_clk_e;

  // One AND term over true and complement columns; no column selected gives low
  function automatic logic pterm(input logic [ARR_W-1:0] a, input logic [ARR_W-1:0] t,
                                 input logic [ARR_W-1:0] c);
    return (|(t | c)) & (&((a | ~t) & (~a | ~c)));
  endfunction
endpackage

/* verilog/cml_macrocell.sv */
// One macrocell: product terms, select matrix, XOR and configurable register.
// Assumes its mode word and masks come from stable configuration storage.
module cml_macrocell
  import cml_pkg::*;
(
  input  wire logic                            clock_in,
  input  wire logic                            rst_n_in,
  input  wire logic                            run_in,
  input  wire logic [31:0]                     mode_in,
  input  wire logic [NUM_PT*PT_WORDS*32-1:0]   masks_in,
  input  wire logic [ARR_W-1:0]                arr_in,
  input  wire logic [1:0]                      gedge_in,
  input  wire logic                            gclr_low_in,
  input  wire logic                            fast_pin_in,
  input  wire logic                            lend_in,
  input  wire logic                            borrow_in,
  output logic                                 prim_out,
  output logic                                 shexp_out,
  output logic                                 mc_out
);
  localparam logic [ARR_W-1:0] ROUTED_ONLY = {{MC_PER_BLOCK{1'b0}}, {NUM_ROUTED{1'b1}}};

  typedef struct packed {
    logic q;
    logic aclk;
    logic pin;
  } cml_mc_s;

  cml_mc_s              st_q, st_d;
  logic [NUM_PT-1:0]    pt, sec, use_or;
  logic                 share, own, x, d, k, clr, pre, ce, aclk, tick, nq;
  cml_ff_e              ff;
  cml_clk_e             cmode;

  // AND array and select matrix
  always_comb begin
    logic [ARR_W-1:0] t;
    logic [ARR_W-1:0] c;
    t = '0;
    c = '0;
    share = mode_in[F_SHARE];
    sec = mode_in[F_SEC +: NUM_PT];
    for (int p = 0; p < NUM_PT; p++) begin
      t = masks_in[p*128 +: ARR_W];
      c = masks_in[p*128+64 +: ARR_W];
      if (p == PT_AUX && share) begin
        pt[p] = pterm(arr_in & ROUTED_ONLY, t & ROUTED_ONLY, c & ROUTED_ONLY);
      end else begin
        pt[p] = pterm(arr_in, t, c);
      end
    end
    use_or = ~sec;
    if (share) begin
      use_or[PT_AUX] = 1'b0;
    end
  end

  // Primary sum, lending, borrowing and polarity
  assign shexp_out = share & ~pt[PT_AUX];
  assign prim_out  = |(pt & use_or);
  assign own       = lend_in ? 1'b0 : prim_out;
  assign x         = (own | borrow_in) ^ mode_in[F_INV];

  // Register inputs and controls
  assign d    = mode_in[F_FAST] ? (mode_in[F_SETUP] ? fast_pin_in : st_q.pin) : x;
  assign k    = pt[PT_AUX] & sec[PT_AUX] & ~share;
  assign clr  = (pt[PT_CLR] & sec[PT_CLR]) | (mode_in[F_GCLR] & ~gclr_low_in);
  assign pre  = pt[PT_PRE] & sec[PT_PRE];
  assign ce   = pt[PT_CE] & sec[PT_CE];
  assign aclk = pt[PT_ACLK] & sec[PT_ACLK];

  // Clock mode and flip-flop type
  always_comb begin
    cmode = cml_clk_e'(mode_in[F_CLK +: 2]);
    ff = cml_ff_e'(mode_in[F_FF +: 2]);
    unique case (cmode)
      CML_CLK_GLOBAL: tick = gedge_in[mode_in[F_GSEL]];
      CML_CLK_GATED:  tick = gedge_in[mode_in[F_GSEL]] & ce;
      CML_CLK_ARRAY:  tick = aclk & ~st_q.aclk;
      default:        tick = 1'b0;
    endcase
    unique case (ff)
      CML_FF_D:  nq = d;
      CML_FF_T:  nq = st_q.q ^ d;
      CML_FF_JK: nq = (d & ~st_q.q) | (~k & st_q.q);
      CML_FF_SR: nq = d | (~k & st_q.q);
    endcase
    st_d = st_q;
    st_d.aclk = aclk;
    st_d.pin = fast_pin_in;
    if (!run_in) begin
      st_d.q = mode_in[F_INIT];
    end else if (clr) begin
      st_d.q = 1'b0;
    end else if (pre) begin
      st_d.q = 1'b1;
    end else if (tick) begin
      st_d.q = nq;
    end
  end

  // Output: combinational bypass or register with asynchronous overrides
  assign mc_out = mode_in[F_BYP] ? x : (run_in & clr) ? 1'b0 : (run_in & pre) ? 1'b1 : st_q.q;

  // State register
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  default clocking mc_cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  a_clear_wins:   assert property (run_in && clr |=> !st_q.q) else $error("clear did not win");
  a_preset_sets:  assert property (run_in && pre && !clr |=> st_q.q) else $error("preset lost");
  a_gclr_forces:  assert property (run_in && mode_in[F_GCLR] && !gclr_low_in && !mode_in[F_BYP]
    |-> !mc_out) else $error("global clear ignored");
  a_init_state:   assert property (!run_in |=> st_q.q == $past(mode_in[F_INIT]))
    else $error("initial state wrong");
  a_hold_no_tick: assert property (run_in && !tick && !clr && !pre |=> $stable(st_q.q))
    else $error("register moved without clock");
  c_array_tick:   cover property (run_in && cmode == CML_CLK_ARRAY && tick);
endmodule // cml_macrocell

/* verilog/cml_fabric.sv */
// Top of the programmable logic fabric: logic blocks, routing array, I/O control, config slave.
// Assumes pins are synchronous to clock_in and software configures over AXI4-Lite.
module cml_fabric
  import cml_pkg::*;
#(
  parameter int NUM_BLOCKS = 2,
  parameter int NUM_OE     = 6,
  parameter int ADDR_W     = 13
) (
  input  wire logic                               clock_in,
  input  wire logic                               rst_n_in,
  input  wire logic                               awvalid_in,
  output logic                                    awready_out,
  input  wire logic [ADDR_W-1:0]                  awaddr_in,
  input  wire logic                               wvalid_in,
  output logic                                    wready_out,
  input  wire logic [31:0]                        wdata_in,
  input  wire logic [3:0]                         wstrb_in,
  output logic                                    bvalid_out,
  input  wire logic                               bready_in,
  output logic [1:0]                              bresp_out,
  input  wire logic                               arvalid_in,
  output logic                                    arready_out,
  input  wire logic [ADDR_W-1:0]                  araddr_in,
  output logic                                    rvalid_out,
  input  wire logic                               rready_in,
  output logic [31:0]                             rdata_out,
  output logic [1:0]                              rresp_out,
  input  wire logic                               global_clock_pin_one_in,
  input  wire logic                               global_clock_pin_two_in,
  input  wire logic                               oe_pin_one_in,
  input  wire logic                               global_clear_pin_low_in,
  input  wire logic [NUM_BLOCKS*MC_PER_BLOCK-1:0] io_in,
  output logic [NUM_BLOCKS*MC_PER_BLOCK-1:0]      io_out,
  output logic [NUM_BLOCKS*MC_PER_BLOCK-1:0]      io_oe_out
);
  localparam int NMC       = NUM_BLOCKS * MC_PER_BLOCK;
  localparam int NSRC      = NUM_DED + 2 * NMC;
  localparam int GBASE     = NUM_BLOCKS * BLOCK_STRIDE;
  localparam int CFG_WORDS = GBASE + STAT_IDX;
  localparam int IDX_W     = ADDR_W - 2;

  typedef struct packed {
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [1:0]      rresp;
    logic [31:0]     rdata;
    logic [NSRC-1:0] src;
    logic [1:0]      gnet;
    logic [NMC-1:0]  pin_out;
    logic [NMC-1:0]  pin_oe;
  } cml_top_s;

  cml_top_s          st_q, st_d;
  logic [31:0]       cfg_mem [CFG_WORDS];
  logic              mem_we;
  logic [31:0]       mem_wmask;
  logic [IDX_W-1:0]  aw_idx, ar_idx;
  logic              aw_take, ar_take, wr_ok, run;
  logic [NUM_DED-1:0] ded;
  logic [NMC-1:0]    mc_out, oe_d;
  logic [NSRC-1:0]   src;
  logic [1:0]        gnet, gedge;
  logic [NUM_OE-1:0] goe;

  // Dedicated inputs double as general routed inputs
  assign ded = {global_clear_pin_low_in, oe_pin_one_in, global_clock_pin_two_in,
                global_clock_pin_one_in};
  // Routing sources: dedicated inputs, pin inputs, macrocell outputs kept apart
  assign src = {mc_out, io_in, ded};
  assign run = cfg_mem[GBASE+CTRL_IDX][0];

  // Global clock nets and their rising-edge enables
  always_comb begin
    logic [31:0] g;
    g = cfg_mem[GBASE+GCLK_IDX];
    for (int n = 0; n < 2; n++) begin
      gnet[n] = (g[2*n] ? ded[DED_CLK2] : ded[DED_CLK1]) ^ g[2*n+1];
      gedge[n] = gnet[n] & ~st_q.gnet[n];
    end
  end

  // Global output enables from any routed source, true or inverted
  always_comb begin
    logic [31:0] w;
    w = '0;
    for (int k = 0; k < NUM_OE; k++) begin
      w = cfg_mem[GBASE+OE_IDX+k];
      goe[k] = (int'(w[6:0]) < NSRC) ? (src[w[6:0]] ^ w[7]) : 1'b0;
    end
  end

  // Per-pin tri-state control selection
  always_comb begin
    logic [3:0] sel;
    int         gi;
    sel = '0;
    gi = 0;
    for (int p = 0; p < NMC; p++) begin
      sel = cfg_mem[GBASE+PIN_IDX+p][3:0];
      gi = int'(sel) - int'(OE_GLOBAL);
      if (sel == OE_TIE_LOW) begin
        oe_d[p] = 1'b0;
      end else if (sel == OE_TIE_HIGH) begin
        oe_d[p] = 1'b1;
      end else begin
        oe_d[p] = (gi < NUM_OE) ? goe[gi] : 1'b0;
      end
    end
  end

  // Assertions below all run on the fabric clock and pause in reset
  default clocking top_cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  // Logic blocks, linked only through the registered routing sources
  for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_blk
    localparam int BB = b * BLOCK_STRIDE;
    logic [NUM_ROUTED-1:0]   routed;
    logic [MC_PER_BLOCK-1:0] shexp, prim, lend_eff, borrow;

    // Routing array: one AND gate per source and block input
    always_comb begin
      logic [ROUTE_WORDS*32-1:0] m;
      m = '0;
      for (int k = 0; k < NUM_ROUTED; k++) begin
        m = {cfg_mem[BB+ROUTE_BASE+3*k+2], cfg_mem[BB+ROUTE_BASE+3*k+1], cfg_mem[BB+ROUTE_BASE+3*k]};
        routed[k] = |(st_q.src & m[NSRC-1:0]);
      end
    end

    // Parallel lending chains
    always_comb begin
      int pos;
      int cnt;
      int li;
      pos = 0;
      cnt = 0;
      li = 0;
      for (int i = 0; i < MC_PER_BLOCK; i++) begin
        pos = i % CHAIN_LEN;
        lend_eff[i] = cfg_mem[BB+i*MC_WORDS][F_LEND] && pos != CHAIN_LEN - 1;
      end
      for (int i = 0; i < MC_PER_BLOCK; i++) begin
        pos = i % CHAIN_LEN;
        cnt = int'(cfg_mem[BB+i*MC_WORDS][F_BORROW +: 2]);
        borrow[i] = 1'b0;
        for (int j = 1; j <= MAX_SETS; j++) begin
          li = (i >= j) ? i - j : 0;
          if (j <= cnt && j <= pos) begin
            borrow[i] = borrow[i] | (lend_eff[li] & prim[li]);
          end
        end
      end
    end

    for (genvar m = 0; m < MC_PER_BLOCK; m++) begin : g_mc
      localparam int MB = BB + m * MC_WORDS;
      logic [NUM_PT*PT_WORDS*32-1:0] masks;

      // Term masks of this macrocell
      always_comb begin
        masks = '0;
        for (int w = 0; w < NUM_PT * PT_WORDS; w++) begin
          masks[w*32 +: 32] = cfg_mem[MB+1+w];
        end
      end

      cml_macrocell u_mc (
        .clock_in    (clock_in),
        .rst_n_in    (rst_n_in),
        .run_in      (run),
        .mode_in     (cfg_mem[MB]),
        .masks_in    (masks),
        .arr_in      ({shexp, routed}),
        .gedge_in    (gedge),
        .gclr_low_in (ded[DED_CLR]),
        .fast_pin_in (io_in[b*MC_PER_BLOCK+m]),
        .lend_in     (lend_eff[m]),
        .borrow_in   (borrow[m]),
        .prim_out    (prim[m]),
        .shexp_out   (shexp[m]),
        .mc_out      (mc_out[b*MC_PER_BLOCK+m])
      );
    end

    a_chain_ends:  assert property (!lend_eff[CHAIN_LEN-1] && !lend_eff[MC_PER_BLOCK-1])
      else $error("chain top cell lends");
    a_chain_split: assert property (!borrow[0] && !borrow[CHAIN_LEN])
      else $error("chain bottom cell borrows");
    // Lending, borrowing and sharing only where configured
    a_lend_cfg:    assert property (!cfg_mem[BB][F_LEND] |-> !lend_eff[0])
      else $error("cell lends unasked");
    a_borrow_cfg:  assert property (cfg_mem[BB+MC_WORDS][F_BORROW +: 2] == 2'h0 |-> !borrow[1])
      else $error("cell borrows unasked");
    a_shexp_off:   assert property (!cfg_mem[BB][F_SHARE] |-> !shexp[0])
      else $error("unshared expander active");
  end

  // Bus decode: write needs address and data together, read answers next cycle
  always_comb begin
    int ri;
    aw_idx = awaddr_in[ADDR_W-1:2];
    ar_idx = araddr_in[ADDR_W-1:2];
    ri = int'(ar_idx);
    aw_take = awvalid_in & wvalid_in & ~st_q.bvalid;
    ar_take = arvalid_in & ~st_q.rvalid;
    wr_ok = int'(aw_idx) < CFG_WORDS;
    mem_we = aw_take & wr_ok;
    for (int i = 0; i < 4; i++) begin
      mem_wmask[8*i +: 8] = {8{wstrb_in[i]}};
    end
    st_d = st_q;
    st_d.src = src;
    st_d.gnet = gnet;
    st_d.pin_out = mc_out;
    st_d.pin_oe = oe_d;
    if (aw_take) begin
      st_d.bvalid = 1'b1;
      st_d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready_in) begin
      st_d.bvalid = 1'b0;
    end
    if (ar_take) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = RESP_OKAY;
      if (ri < CFG_WORDS) begin
        st_d.rdata = cfg_mem[ar_idx];
      end else if (ri == GBASE + STAT_IDX) begin
        st_d.rdata = 32'(io_in);
      end else if (ri == GBASE + STAT_IDX + 1) begin
        st_d.rdata = 32'(mc_out);
      end else if (ri == GBASE + STAT_IDX + 2) begin
        st_d.rdata = 32'(ded);
      end else begin
        st_d.rdata = '0;
        st_d.rresp = RESP_SLVERR;
      end
    end else if (rready_in) begin
      st_d.rvalid = 1'b0;
    end
  end

  // Handshake and pin outputs
  assign awready_out = aw_take;
  assign wready_out  = aw_take;
  assign arready_out = ar_take;
  assign bvalid_out  = st_q.bvalid;
  assign bresp_out   = st_q.bresp;
  assign rvalid_out  = st_q.rvalid;
  assign rdata_out   = st_q.rdata;
  assign rresp_out   = st_q.rresp;
  assign io_out      = st_q.pin_out;
  assign io_oe_out   = st_q.pin_oe;

  // Configuration storage with byte strobes
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < CFG_WORDS; i++) begin
        cfg_mem[i] <= CFG_RESET;
      end
    end else if (mem_we) begin
      cfg_mem[aw_idx] <= (cfg_mem[aw_idx] & ~mem_wmask) | (wdata_in & mem_wmask);
    end
  end

  // State register
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Pin enables, global clock nets and dedicated input status
  a_oe_tie_low:  assert property (cfg_mem[GBASE+PIN_IDX][3:0] == OE_TIE_LOW |=> !io_oe_out[0])
    else $error("tied-low pin drives");
  a_oe_tie_high: assert property (cfg_mem[GBASE+PIN_IDX][3:0] == OE_TIE_HIGH |=> io_oe_out[0])
    else $error("tied-high pin floats");
  a_oe_global:   assert property (cfg_mem[GBASE+PIN_IDX+3][3:0] == OE_GLOBAL
    |=> io_oe_out[3] == $past(goe[0])) else $error("pin ignores global enable");
  a_gclk_edge:   assert property (gedge[0] |-> gnet[0] && !$past(gnet[0]))
    else $error("global clock edge without rise");
  a_rd_ded:      assert property (arvalid_in && arready_out && int'(araddr_in[ADDR_W-1:2]) == CFG_WORDS + 2
    |=> rdata_out == 32'($past(ded))) else $error("dedicated input status wrong");

  // Bus handshake: refusals, answers and stored words
  a_bresp_hold:  assert property (bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
    else $error("write answer dropped");
  a_read_answer: assert property (arvalid_in && arready_out |=> rvalid_out)
    else $error("read not answered");
  a_rdata_hold:  assert property (rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out) && $stable(rresp_out))
    else $error("read answer changed");
  a_wr_refused:  assert property (bvalid_out |-> !awready_out && !wready_out)
    else $error("write taken while answer pending");
  a_rd_refused:  assert property (rvalid_out |-> !arready_out)
    else $error("read taken while answer pending");
  a_aw_ready:    assert property (awvalid_in && wvalid_in && !bvalid_out |-> awready_out && wready_out)
    else $error("free write not taken");
  a_ar_ready:    assert property (arvalid_in && !rvalid_out |-> arready_out)
    else $error("free read not taken");
  a_wr_answer:   assert property (awvalid_in && awready_out |=> bvalid_out)
    else $error("write not answered");
  a_bvalid_drop: assert property (bvalid_out && bready_in |=> !bvalid_out)
    else $error("write answer stuck");
  a_rvalid_drop: assert property (rvalid_out && rready_in |=> !rvalid_out)
    else $error("read answer stuck");
  a_wr_slverr:   assert property (awvalid_in && awready_out && int'(awaddr_in[ADDR_W-1:2]) >= CFG_WORDS
    |=> bresp_out == RESP_SLVERR) else $error("write outside storage accepted");
  a_wr_lands:    assert property (mem_we && wstrb_in == 4'hF |=> cfg_mem[$past(aw_idx)] == $past(wdata_in))
    else $error("written word not stored");
  a_rd_range:    assert property (arvalid_in && arready_out && int'(araddr_in[ADDR_W-1:2]) > CFG_WORDS + 2
    |=> rresp_out == RESP_SLVERR && rdata_out == 32'h0) else $error("unmapped read answered");

  // Main scenarios reached
  c_gclk_rise:   cover property (gedge[0]);
  c_write:       cover property (awvalid_in && awready_out ##1 bvalid_out && bready_in);
  c_bad_read:    cover property (rvalid_out && rresp_out == RESP_SLVERR);
  c_pin_drive:   cover property (!io_oe_out[0] ##1 io_oe_out[0]);
endmodule // cml_fabric

/* dv/cml_board.sv */
// Board-side model of the logic that meets the fabric's I/O pins.
// Assumes the fabric reports pin drive as io_out/io_oe; resolves each wire.
module cml_board #(
  parameter int N = 32
) (
  input  wire logic         clock_in,
  input  wire logic [N-1:0] drive_val_in,
  input  wire logic [N-1:0] drive_en_in,
  input  wire logic [N-1:0] io_out_in,
  input  wire logic [N-1:0] io_oe_in,
  output logic [N-1:0]      pin_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [N-1:0] float_q = '0;
  // Undriven wires wander each cycle, so a stale level never reads as valid
  always_ff @(posedge clock_in) begin
    float_q <= ~float_q;
  end
  // Fabric wins where it drives; the board only drives released pins
  assign pin_out = (io_oe_in & io_out_in) | (~io_oe_in & drive_en_in & drive_val_in)
                 | (~io_oe_in & ~drive_en_in & float_q);
endmodule // cml_board

/* dv/cml_fabric_bench.sv */
// Self-checking bench for the logic fabric: bus access, pin paths, register modes.
// Assumes the default fabric size (2 blocks, 32 pins) and the board model beside it.
module cml_fabric_bench
  import cml_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int G = 1024;
  logic        clock_in, rst_n_in, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, clk1, clk2, oe1, clr_n;
  logic [12:0] awaddr, araddr;
  logic [31:0] wdata, rdata, io_in, io_out, io_oe, board_val, board_en, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;

  cml_fabric DUT (.clock_in(clock_in), .rst_n_in(rst_n_in), .awvalid_in(awvalid), .awready_out(awready),
    .awaddr_in(awaddr), .wvalid_in(wvalid), .wready_out(wready), .wdata_in(wdata), .wstrb_in(wstrb),
    .bvalid_out(bvalid), .bready_in(bready), .bresp_out(bresp), .arvalid_in(arvalid),
    .arready_out(arready), .araddr_in(araddr), .rvalid_out(rvalid), .rready_in(rready),
    .rdata_out(rdata), .rresp_out(rresp), .global_clock_pin_one_in(clk1), .global_clock_pin_two_in(clk2),
    .oe_pin_one_in(oe1), .global_clear_pin_low_in(clr_n), .io_in(io_in), .io_out(io_out),
    .io_oe_out(io_oe));
  cml_board u_board (.clock_in(clock_in), .drive_val_in(board_val), .drive_en_in(board_en),
    .io_out_in(io_out), .io_oe_in(io_oe), .pin_out(io_in));

  // Verdict and end of run
  task automatic test_done();
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Compare helpers, one per result kind
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk_word({30'h0, got}, {30'h0, exp});
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  // Expected level of a bypassed cell with optional output inversion
  function automatic logic exp_comb(input logic d, input logic inv);
    return d ^ inv;
  endfunction
  // One write: address and data offered together, held until taken
  task automatic wr(input int idx, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock_in);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= 13'(idx * 4);
    wdata   <= d;
    bready  <= 1'b1;
    do @(negedge clock_in); while (!(awready === 1'b1 && wready === 1'b1));
    @(posedge clock_in);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(negedge clock_in); while (bvalid !== 1'b1);
    chk_resp(bresp, er);
    @(posedge clock_in);
    bready <= 1'b0;
  endtask
  // One read, data and response checked when the answer arrives
  task automatic rd(input int idx, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clock_in);
    arvalid <= 1'b1;
    araddr  <= 13'(idx * 4);
    rready  <= 1'b1;
    do @(negedge clock_in); while (arready !== 1'b1);
    @(posedge clock_in);
    arvalid <= 1'b0;
    do @(negedge clock_in); while (rvalid !== 1'b1);
    chk_resp(rresp, er);
    chk_word(rdata, ed);
    @(posedge clock_in);
    rready <= 1'b0;
  endtask
  // Set pin 0, clock pin one and clear pin, then let the paths settle
  task automatic drive(input logic d, input logic c, input logic cl);
    @(posedge clock_in);
    board_val[0] <= d;
    clk1         <= c;
    clr_n        <= cl;
    repeat (5) @(posedge clock_in);
    @(negedge clock_in);
  endtask

  // Free-running 100 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // Hang guard
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    rst_n_in = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, clk1, clk2, oe1} = '0;
    clr_n = 1'b1;
    {awaddr, araddr, wdata, board_val, board_en} = '0;
    wstrb = 4'hF;
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
    void'($urandom(2));
    // Reset value, unmapped and read-only places
    rd(G, CFG_RESET, RESP_OKAY);
    rd(G + 99, 32'h0, RESP_SLVERR);
    wr(G + 96, 32'h1, RESP_SLVERR);
    wr(1120, 32'h5, RESP_SLVERR);
    // Byte strobes: only lane 1 of a global enable word lands
    wstrb <= 4'h2;
    wr(G + 3, 32'hFFFFFFFF, RESP_OKAY);
    wstrb <= 4'hF;
    rd(G + 3, 32'h0000FF00, RESP_OKAY);
    // Cell 2: D register, global clock, init high, global clear enabled
    wr(2 * 21, 32'h180, RESP_OKAY);
    repeat (4) @(posedge clock_in);
    @(negedge clock_in);
    chk_pin(io_out[2], 1'b1);
    // Cell 1 bypassed and inverted, terms of cells 1 and 2 read pin 0
    wr(21, 32'h44, RESP_OKAY);
    wr(22, 32'h1, RESP_OKAY);
    wr(43, 32'h1, RESP_OKAY);
    wr(336, 32'h10, RESP_OKAY);
    wr(G + 16, 32'(OE_TIE_LOW), RESP_OKAY);
    wr(G + 17, 32'(OE_TIE_HIGH), RESP_OKAY);
    wr(G + 2, 32'h2, RESP_OKAY);
    wr(G + 19, 32'(OE_GLOBAL), RESP_OKAY);
    wr(G + 1, 32'h0, RESP_OKAY);
    wr(G, 32'h1, RESP_OKAY);
    @(negedge clock_in);
    chk_pin(io_oe[1], 1'b1);
    chk_pin(io_oe[0], 1'b0);
    rd(21, 32'h44, RESP_OKAY);
    // Random pin levels through routing, bypassed cell and global enable
    repeat (24) begin
      @(posedge clock_in);
      v = $urandom;
      board_val <= v;
      board_en  <= $urandom | 32'h1;
      oe1       <= v[5];
      repeat (4) @(posedge clock_in);
      @(negedge clock_in);
      chk_pin(io_out[1], exp_comb(v[0], 1'b1));
      chk_pin(io_oe[3], v[5]);
    end
    // Register clocked only by rising edges of the global net
    drive(1'b0, 1'b0, 1'b1);
    drive(1'b0, 1'b1, 1'b1);
    chk_pin(io_out[2], 1'b0);
    drive(1'b1, 1'b1, 1'b1);
    chk_pin(io_out[2], 1'b0);
    drive(1'b1, 1'b0, 1'b1);
    drive(1'b1, 1'b1, 1'b1);
    chk_pin(io_out[2], 1'b1);
    drive(1'b1, 1'b1, 1'b0);
    chk_pin(io_out[2], 1'b0);
    drive(1'b1, 1'b1, 1'b1);
    chk_pin(io_out[2], 1'b0);
    // Inverted net: a falling pin edge now clocks the register
    wr(G + 1, 32'h2, RESP_OKAY);
    drive(1'b1, 1'b0, 1'b1);
    chk_pin(io_out[2], 1'b1);
    rd(G + 98, {28'h0, clr_n, oe1, clk2, clk1}, RESP_OKAY);
    test_done();
  end
endmodule // cml_fabric_bench
